/* powerup_test_ctl.sv */
// top of the power-up reset, register preload and observe logic of the device
// assumes pins are synchronous to SYS_CLK_I; the tester drives the mode pins
`timescale 1ns/1ns
module powerup_test_ctl #(
  parameter int N_OUT = testmode_pkg::NUM_OUT_CELLS,
  parameter int N_BUR = testmode_pkg::NUM_BURIED_CELLS
) (
  // clock, reset, enable
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // test mode pins
  input wire logic [1:0] TEST_MODE_I,
  input wire logic BANK_SEL_I,
  // user logic and configuration
  input wire logic [N_OUT+N_BUR-1:0] PTERM_SUM_I,
  input wire logic [N_OUT-1:0] CELL_COMB_I,
  input wire logic [N_OUT-1:0] POLARITY_I,
  input wire logic [N_OUT-1:0] USER_OE_I,
  input wire logic [N_OUT+N_BUR-1:0] AR_SEL_I,
  input wire logic [N_OUT+N_BUR-1:0] AP_SEL_I,
  // I/O pins as three signals
  input wire logic [N_OUT-1:0] IO_IN_I,
  output logic [N_OUT-1:0] IO_OUT_O,
  output logic [N_OUT-1:0] IO_OE_O,
  // status
  output logic RESET_DONE_O
);
  localparam int N = N_OUT + N_BUR;

  cell_bus_if #(.N(N)) cbus ();

  testmode_pkg::ctl_state_t state_r;
  testmode_pkg::ctl_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [N-1:0] d_cells;
  logic [N-1:0] load_val;
  logic [N_OUT-1:0] comb_val;
  logic [N_OUT-1:0] out_nxt;
  logic [N_OUT-1:0] oe_nxt;
  logic [N_OUT-1:0] shown;
  logic forced;
  logic done_nxt;

  // mode sequencing; reset clears cells for a bounded count before running
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      testmode_pkg::ST_RESET: begin
        if (cnt_r >= 16'(testmode_pkg::PWRUP_CYCLES - 1)) begin
          state_nxt = testmode_pkg::ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      testmode_pkg::ST_RUN, testmode_pkg::ST_PRELOAD, testmode_pkg::ST_OBSERVE: begin
        // tester owns entry and exit of the test modes
        if (TEST_MODE_I == testmode_pkg::MODE_PRELOAD) begin
          state_nxt = testmode_pkg::ST_PRELOAD;
        end else if (TEST_MODE_I == testmode_pkg::MODE_OBSERVE) begin
          state_nxt = testmode_pkg::ST_OBSERVE;
        end else begin
          state_nxt = testmode_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_r <= testmode_pkg::ST_RESET;
      cnt_r <= 16'h0000;
    end else if (CE_I) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign forced = (state_r == testmode_pkg::ST_PRELOAD) || (state_r == testmode_pkg::ST_OBSERVE);

  // preload bank select: output cells or buried cells share the few I/O pins
  always_comb begin
    load_val = cbus.q;
    if (BANK_SEL_I) begin
      load_val[N-1:N_OUT] = IO_IN_I[N_BUR-1:0];
    end else begin
      load_val[N_OUT-1:0] = IO_IN_I;
    end
  end

  // while forced all product terms read zero, so no combinatorial data survives
  assign d_cells = forced ? '0 : PTERM_SUM_I;

  assign cbus.clr = (state_r == testmode_pkg::ST_RESET);
  assign cbus.load = (state_r == testmode_pkg::ST_PRELOAD);
  assign cbus.force_reg = forced;
  assign cbus.load_val = load_val;

  macrocell_array #(.N(N)) u_cells (
    .clk_i(SYS_CLK_I),
    .ce_i(CE_I),
    .bus(cbus),
    .d_i(d_cells),
    .ar_sel_i(AR_SEL_I),
    .ap_sel_i(AP_SEL_I)
  );

  // combinatorial cells take live sums again once out of test
  assign comb_val = forced ? '0 : PTERM_SUM_I[N_OUT-1:0];

  // observe picks the bank to show; normal shows output registers
  assign shown = (BANK_SEL_I && state_r == testmode_pkg::ST_OBSERVE)
    ? cbus.q[N-1:N_OUT] : cbus.q[N_OUT-1:0];

  // pin drivers; cleared registers still pass through polarity
  always_comb begin
    for (int i = 0; i < N_OUT; i++) begin
      if (forced) begin
        out_nxt[i] = shown[i] ^ POLARITY_I[i];
      end else if (CELL_COMB_I[i]) begin
        out_nxt[i] = comb_val[i] ^ POLARITY_I[i];
      end else begin
        out_nxt[i] = shown[i] ^ POLARITY_I[i];
      end
    end
    if (state_r == testmode_pkg::ST_OBSERVE) begin
      oe_nxt = '1;
    end else if (state_r == testmode_pkg::ST_PRELOAD) begin
      oe_nxt = '0; // pins are inputs while loading
    end else begin
      oe_nxt = USER_OE_I;
    end
    done_nxt = (state_r != testmode_pkg::ST_RESET);
  end

  // registered outputs keep the pins glitch-free across mode changes
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      IO_OUT_O <= '0;
      IO_OE_O <= '0;
      RESET_DONE_O <= 1'h0;
    end else if (CE_I) begin
      IO_OUT_O <= out_nxt;
      IO_OE_O <= oe_nxt;
      RESET_DONE_O <= done_nxt;
    end
  end
endmodule : powerup_test_ctl

/* testmode_pkg.sv */
// package for the power-up reset, preload and observe test logic
// assumes a single 25 MHz system clock and no software-visible registers
package testmode_pkg;

  // clock rate and power-up reset bound
  localparam int CLK_HZ = 25000000;
  localparam int PWRUP_RESET_US = 10;
  // longest time rounds down, never below one cycle
  localparam int PWRUP_CYCLES_RAW = (PWRUP_RESET_US * (CLK_HZ / 1000000));
  localparam int PWRUP_CYCLES = (PWRUP_CYCLES_RAW < 1) ? 1 : PWRUP_CYCLES_RAW;

  // macrocell counts
  localparam int NUM_OUT_CELLS = 8;
  localparam int NUM_BURIED_CELLS = 8;

  // value of every macrocell flip-flop after power-up reset
  localparam logic FF_RESET_VAL = 1'h0;

  // test-mode selection codes on the mode pins
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PRELOAD = 2'h1;
  localparam logic [1:0] MODE_OBSERVE = 2'h2;

  // one-hot control states
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_RUN = 4'h2,
    ST_PRELOAD = 4'h4,
    ST_OBSERVE = 4'h8
  } ctl_state_t;

endpackage : testmode_pkg

/* cell_bus_if.sv */
// interface carrying per-macrocell controls from the test controller to the cell array
// assumes both ends run on the one system clock
`timescale 1ns/1ns
interface cell_bus_if #(parameter int N = 16);
  logic clr;
  logic load;
  logic force_reg;
  logic [N-1:0] load_val;
  logic [N-1:0] q;
  modport ctl (output clr, output load, output force_reg, output load_val, input q);
  modport cells (input clr, input load, input force_reg, input load_val, output q);
endinterface : cell_bus_if

/* macrocell_array.sv */
// array of macrocell flip-flops with preload, clear and async set/reset from feedback
// assumes the controller drives cell_bus_if; logic inputs come from the user array
`timescale 1ns/1ns
module macrocell_array #(
  parameter int N = 16
) (
  input wire logic clk_i,
  input wire logic ce_i,
  cell_bus_if.cells bus,
  input wire logic [N-1:0] d_i,
  input wire logic [N-1:0] ar_sel_i,
  input wire logic [N-1:0] ap_sel_i
) ;
  logic [N-1:0] q_r;
  logic [N-1:0] q_nxt;
  logic ar_line;
  logic ap_line;

  // async reset/preset lines are driven by the registers themselves
  assign ar_line = |(q_r & ar_sel_i);
  assign ap_line = |(q_r & ap_sel_i);

  // priority: power-up clear, then preload, then register-driven reset/preset
  genvar g;
  for (g = 0; g < N; g++) begin : g_cell
    always_comb begin
      if (bus.clr) begin
        q_nxt[g] = testmode_pkg::FF_RESET_VAL;
      end else if (bus.load) begin
        q_nxt[g] = bus.load_val[g];
      end else if (ar_line) begin
        q_nxt[g] = 1'h0;
      end else if (ap_line) begin
        q_nxt[g] = 1'h1;
      end else if (bus.force_reg) begin
        q_nxt[g] = q_r[g]; // hold while observed
      end else begin
        q_nxt[g] = d_i[g];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  assign bus.q = q_r;
endmodule : macrocell_array

/* powerup_test_ctl_chk.sv */
// pin assertions for the test-mode logic
// assumes clock enable held high
`timescale 1ns/1ns
module powerup_test_ctl_chk #(
  parameter int N_OUT = 8,
  parameter int N_BUR = 8
) (
  // clock, reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // pins
  input wire logic [1:0] TEST_MODE_I,
  input wire logic BANK_SEL_I,
  input wire logic [N_OUT-1:0] POLARITY_I,
  input wire logic [N_OUT+N_BUR-1:0] AR_SEL_I,
  input wire logic [N_OUT-1:0] IO_IN_I,
  input wire logic [N_OUT-1:0] IO_OUT_O,
  input wire logic [N_OUT-1:0] IO_OE_O,
  input wire logic RESET_DONE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // one held observe step; reset lines quiet so only the preset line can move contents
  sequence obs_s;
    RESET_DONE_O && TEST_MODE_I == 2'h2 && AR_SEL_I == '0 && $stable(BANK_SEL_I);
  endsequence
  // one held bank-0 preload step with steady pin data
  sequence pl_s;
    RESET_DONE_O && TEST_MODE_I == 2'h1 && !BANK_SEL_I && $stable(IO_IN_I);
  endsequence
  a_clr_quiet: assert property ($fell(RST_I) |-> (!RESET_DONE_O && IO_OE_O == '0) [*8])
    else $error("clear");
  a_clr_bound: assert property ($fell(RST_I) |-> ##[1:256] RESET_DONE_O)
    else $error("slow");
  a_done_held: assert property (RESET_DONE_O |=> RESET_DONE_O)
    else $error("done");
  a_idle_level: assert property ($rose(RESET_DONE_O) |-> ##[0:1] IO_OUT_O == POLARITY_I)
    else $error("level");
  a_obs_drive: assert property (obs_s [*3] |=> IO_OE_O == '1)
    else $error("obs oe");
  a_pl_float: assert property (pl_s [*3] |=> IO_OE_O == '0)
    else $error("pl oe");
  a_pl_show: assert property (pl_s [*4] |=> IO_OUT_O == ($past(IO_IN_I) ^ POLARITY_I))
    else $error("pl data");
  a_obs_hold: assert property (obs_s [*4] |=> $stable(IO_OUT_O))
    else $error("hold");
endmodule : powerup_test_ctl_chk
bind powerup_test_ctl powerup_test_ctl_chk #(.N_OUT(N_OUT), .N_BUR(N_BUR)) chk_u (.*);

/* tester_model.sv */
// tester model for mode pins and shared I/O pins
// assumes drive() is entered just after a rising edge
`timescale 1ns/1ns
module tester_model (
  // clock and device side
  input wire logic clk_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  // tester side
  output logic [1:0] mode_o = 2'h0,
  output logic bank_o = 1'h0,
  output logic [7:0] pin_o
);
  logic [7:0] val = 8'h00;
  logic pl_q = 1'h0;
  // the device leaves preload one edge after the mode pins do, so data stays one edge longer
  always @(posedge clk_i) pl_q <= (mode_o == 2'h1);
  // device wins where enabled; tester drives only in preload, else pull-ups
  assign pin_o = (oe_i & out_i) | (~oe_i & ((mode_o == 2'h1 || pl_q) ? val : 8'hFF));
  // hold one mode for n edges; t_async picks data that fires the reset line, t_preload keeps it quiet
  task automatic drive(input logic [1:0] m, input logic b, input logic [7:0] v, input int n);
    mode_o = m;
    bank_o = b;
    if (m == 2'h1) val = v;
    repeat (n) @(posedge clk_i);
    #1;
  endtask : drive
endmodule : tester_model

/* powerup_reset_preload_observe_bench.sv */
// bench for power-up clear, preload and observe
// assumes eight output and eight buried cells
`timescale 1ns/1ns
module powerup_reset_preload_observe_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [15:0] pt = 16'h0000;
  logic [15:0] ar = 16'h0000;
  logic [7:0] cmb = 8'h00;
  logic [7:0] pol = 8'hA5;
  logic [7:0] pin, dout, oe;
  logic [1:0] mode;
  logic bank, done;
  int n_fail = 0;
  int total_checks = 0;
  // 25 MHz
  always #20 clk = ~clk;
  powerup_test_ctl dut_u (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'h1), .TEST_MODE_I(mode),
    .BANK_SEL_I(bank), .PTERM_SUM_I(pt), .CELL_COMB_I(cmb), .POLARITY_I(pol), .USER_OE_I(8'h00),
    .AR_SEL_I(ar), .AP_SEL_I(16'h0000), .IO_IN_I(pin), .IO_OUT_O(dout), .IO_OE_O(oe),
    .RESET_DONE_O(done));
  tester_model tm_u (.clk_i(clk), .out_i(dout), .oe_i(oe), .mode_o(mode), .bank_o(bank),
    .pin_o(pin));
  // count one comparison
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %0t %h %h", $time, g, e);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // clear plus done register fits 256 edges; pins then show polarity
  task automatic t_powerup;
    repeat (256) @(posedge clk);
    #1;
    chk({7'h00, done}, 8'h01);
    chk(dout, pol);
  endtask : t_powerup
  // both banks loaded then observed; all-one terms must not leak through
  task automatic t_preload;
    logic [7:0] v[2] = '{8'h3C, 8'hC3};
    pt = 16'hFFFF;
    cmb = 8'hF0;
    for (int b = 0; b < 2; b++) begin
      tm_u.drive(2'h1, b[0], v[b], 6);
      chk(oe, 8'h00);
      tm_u.drive(2'h2, b[0], 8'h00, 6);
      chk(oe, 8'hFF);
      chk(dout, v[b] ^ pol);
    end
  endtask : t_preload
  // a loaded one feeding the reset line clears itself, then normal again
  task automatic t_async;
    ar = 16'h0001;
    tm_u.drive(2'h1, 1'h0, 8'h01, 6);
    tm_u.drive(2'h2, 1'h0, 8'h00, 6);
    chk(dout, pol);
    ar = 16'h0000;
    tm_u.drive(2'h0, 1'h0, 8'h00, 4);
    chk(dout & 8'hF0, ~pol & 8'hF0);
  endtask : t_async
  // watchdog far past the few hundred cycles needed
  initial begin
    #80000;
    n_fail++;
    give_verdict();
  end
  // 16 reset cycles; mode pins stay idle through the clear
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'h0;
    t_powerup();
    t_preload();
    t_async();
    give_verdict();
  end
endmodule : powerup_reset_preload_observe_bench
